// ===== core/motor_start_supervisor.sv
`timescale 1ns/1ps
`include "motor_start_supervisor_map.svh"
// Summary of operation
// [R1] Definite mode: time the start/stall condition against the starting time
// [R2] Heat-integral mode: accumulate current squared and compare to a limit
// [R3] Starting time set in 5 ms steps up to 1800 s, default 40 ms; the code takes any 19-bit value, up to 2621.435 s
// [R4] Speed switch supervision enable, off by default, gates wait/polarity
// [R5] Halt start if speed switch not active within wait time
// [R6] Speed switch read as normally open or normally closed
// [R7] Scope selects start-up only or start-up plus stall supervision
// [R8] Start output while condition holds and function is not blocked, also after trip
// [R9] Trip output once pick-up and timing conditions are both met
// [R10] Blocked output when start would be active but function is blocked
// [R11] Paired on/off events for seven supervision conditions
// [R12] Per-event choice of storing on, off or both messages
// [R13] Every event carries a time stamp
// [R14] Keep only the twelve most recent operation records
// [R15] Record holds stamp, event, duration, percent, thermal, currents, group
// [R16] When twelve are held, the oldest record is overwritten
module motor_start_supervisor
  import motor_start_supervisor_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MSS_STEP_NS / `MSS_CLK_NS
) (
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Process inputs
  input  wire logic        i_start_cond,
  input  wire logic        i_stall_cond,
  input  wire logic        i_speed_switch,
  input  wire logic        i_block,
  input  wire meas_t       i_meas,
  input  wire logic [47:0] i_stamp,
  // Function outputs
  output logic             o_start,
  output logic             o_trip,
  output logic             o_blocked,
  output logic             o_irq,
  // Event port towards the main event buffer
  output logic [6:0]       o_evt_on,
  output logic [6:0]       o_evt_off,
  output logic [47:0]      o_evt_stamp
);

  logic rst_meta;
  logic rst_sync_n;

  // Reset asserts at once and releases after two clock edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Slot of a record counted back from the newest one
  function automatic logic [3:0] rec_index(input logic [3:0] ptr,
                                           input logic [3:0] sel);
    logic [4:0] v;
    v = 5'(ptr) + 5'(`MSS_NREC) - 5'd1 - 5'(sel);
    if (v >= 5'(`MSS_NREC)) begin
      v = v - 5'(`MSS_NREC);
    end
    return v[3:0];
  endfunction

  cfg_t        cfg, next_cfg;
  logic [6:0]  irq_stat, next_irq_stat;
  logic [6:0]  irq_en, next_irq_en;
  logic [3:0]  rec_sel, next_rec_sel;
  logic [31:0] next_rdata;
  logic        next_irq;

  sup_state_t  state, next_state;
  logic [19:0] tick_cnt, next_tick_cnt;
  logic [18:0] elapsed, next_elapsed;
  logic [31:0] heat_acc, next_heat_acc;
  logic        sw_seen, next_sw_seen;
  logic [6:0]  flags, next_flags;
  logic [6:0]  next_evt_on, next_evt_off;

  rec_t        rec_mem [`MSS_NREC];
  rec_t        new_rec;
  logic [3:0]  wr_ptr, next_wr_ptr;
  logic [3:0]  rec_cnt, next_rec_cnt;
  logic        rec_we;
  rec_t        rd_rec;

  logic        tick;
  logic        cond;
  logic        sw_active;
  logic        set_exceed, max_exceed, sw_fail, trip_met;
  logic [6:0]  rise, fall;
  logic [31:0] pct32;

  // Record fields seen through the read port follow rec_sel
  assign rd_rec = rec_mem[rec_index(wr_ptr, rec_sel)];

  // Supervision engine
  always_comb begin
    tick       = (tick_cnt == 20'(TICK_CYCLES - 1));
    cond       = i_start_cond | (cfg.stall_too & i_stall_cond);  // [R7]
    sw_active  = i_speed_switch ^ cfg.speed_switch_polarity;    // [R6]
    next_state    = state;
    next_tick_cnt = tick ? 20'h00000 : tick_cnt + 20'h00001;
    next_elapsed  = elapsed;
    next_heat_acc = heat_acc;
    next_sw_seen  = sw_seen;
    case (state)
      ST_IDLE: begin
        next_tick_cnt = 20'h00000;
        if (cond) begin
          next_state    = ST_TIMING;
          next_elapsed  = 19'h00000;
          next_heat_acc = 32'h00000000;
          next_sw_seen  = 1'b0;
        end
      end
      ST_TIMING: begin
        if (!cond) begin
          next_state = ST_IDLE;
        end
        if (sw_active) begin
          next_sw_seen = 1'b1;
        end
        if (tick) begin
          if (elapsed != 19'h7ffff) begin
            next_elapsed = elapsed + 19'h00001;
          end
          if (heat_acc > 32'hffffffff - 32'(i_meas.i_sq)) begin
            next_heat_acc = 32'hffffffff;
          end else begin
            next_heat_acc = heat_acc + 32'(i_meas.i_sq);  // [R2]
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase

    set_exceed = (state == ST_TIMING) && cond
                 && (elapsed >= cfg.start_time);              // [R1] [R3]
    max_exceed = (state == ST_TIMING) && cond
                 && (heat_acc >= cfg.heat_limit);             // [R2]
    sw_fail    = (state == ST_TIMING) && cond && cfg.speed_switch_en
                 && !sw_seen && !sw_active
                 && (elapsed >= cfg.speed_switch_timeout);    // [R4] [R5]
    trip_met   = cfg.heat_integral_mode ? max_exceed : set_exceed;

    // A missing speed switch halts the start via the set-time trip
    next_flags = '0;
    next_flags[`MSS_EV_MAX]   = max_exceed;
    next_flags[`MSS_EV_SET]   = set_exceed;
    next_flags[`MSS_EV_SW]    = sw_fail;
    next_flags[`MSS_EV_START] = cond && !i_block;               // [R8]
    next_flags[`MSS_EV_STRIP] = !i_block && (sw_fail
                                || (trip_met && !cfg.heat_integral_mode));
    next_flags[`MSS_EV_CTRIP] = !i_block && cfg.heat_integral_mode
                                && trip_met;                    // [R9]
    next_flags[`MSS_EV_BLK]   = cond && i_block;                // [R10]

    rise = next_flags & ~flags;                                 // [R11]
    fall = flags & ~next_flags;
    next_evt_on  = rise & cfg.evt_sel[6:0];                     // [R12]
    next_evt_off = fall & cfg.evt_sel[13:7];
  end

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state       <= ST_IDLE;
      tick_cnt    <= 20'h00000;
      elapsed     <= 19'h00000;
      heat_acc    <= 32'h00000000;
      sw_seen     <= 1'b0;
      flags       <= 7'h00;
      o_start     <= 1'b0;
      o_trip      <= 1'b0;
      o_blocked   <= 1'b0;
      o_evt_on    <= 7'h00;
      o_evt_off   <= 7'h00;
      o_evt_stamp <= 48'h000000000000;
    end else if (i_ce) begin
      state       <= next_state;
      tick_cnt    <= next_tick_cnt;
      elapsed     <= next_elapsed;
      heat_acc    <= next_heat_acc;
      sw_seen     <= next_sw_seen;
      flags       <= next_flags;
      o_start     <= next_flags[`MSS_EV_START];
      o_trip      <= next_flags[`MSS_EV_STRIP] | next_flags[`MSS_EV_CTRIP];
      o_blocked   <= next_flags[`MSS_EV_BLK];
      o_evt_on    <= next_evt_on;
      o_evt_off   <= next_evt_off;
      o_evt_stamp <= i_stamp;                                   // [R13]
    end
  end

  // Operation record store
  always_comb begin
    // A record is taken on the rising edge of either trip
    rec_we = rise[`MSS_EV_STRIP] | rise[`MSS_EV_CTRIP];
    if (cfg.start_time == 19'h00000) begin
      pct32 = 32'(`MSS_PCT_FULL);
    end else begin
      pct32 = (32'(elapsed) * 32'(`MSS_PCT_FULL)) / 32'(cfg.start_time);
    end
    new_rec.stamp      = i_stamp;                               // [R15]
    new_rec.event_code = rise[`MSS_EV_CTRIP] ? 3'(`MSS_EV_CTRIP)
                                             : 3'(`MSS_EV_STRIP);
    new_rec.duration   = elapsed;
    new_rec.pct_used   = (pct32 > 32'h0000ffff) ? 16'hffff : pct32[15:0];
    new_rec.thermal    = i_meas.thermal;
    new_rec.l1         = i_meas.l1;
    new_rec.l2         = i_meas.l2;
    new_rec.l3         = i_meas.l3;
    new_rec.group      = i_meas.group;
    next_wr_ptr  = wr_ptr;
    next_rec_cnt = rec_cnt;
    if (rec_we) begin
      next_wr_ptr = (wr_ptr == 4'(`MSS_NREC - 1)) ? 4'h0
                                                   : wr_ptr + 4'h1;  // [R16]
      if (rec_cnt != 4'(`MSS_NREC)) begin
        next_rec_cnt = rec_cnt + 4'h1;                          // [R14]
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ptr  <= 4'h0;
      rec_cnt <= 4'h0;
    end else if (i_ce) begin
      wr_ptr  <= next_wr_ptr;
      rec_cnt <= next_rec_cnt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && rec_we) begin
      rec_mem[wr_ptr] <= new_rec;                               // [R14]
    end
  end

  // Register file and interrupt
  always_comb begin
    next_cfg      = cfg;
    next_irq_en   = irq_en;
    next_rec_sel  = rec_sel;
    next_irq_stat = irq_stat;
    if (i_wr) begin
      case (i_addr)
        `MSS_A_CTRL: begin
          next_cfg.heat_integral_mode    = i_wdata[`MSS_B_HEAT];
          next_cfg.speed_switch_en       = i_wdata[`MSS_B_SWEN];
          next_cfg.speed_switch_polarity = i_wdata[`MSS_B_SWPOL];
          next_cfg.stall_too             = i_wdata[`MSS_B_STALL];
        end
        `MSS_A_START_T:  next_cfg.start_time = i_wdata[18:0];
        `MSS_A_SW_TO:    next_cfg.speed_switch_timeout = i_wdata[18:0];
        `MSS_A_HEAT_LIM: next_cfg.heat_limit = i_wdata;
        `MSS_A_EVT_SEL:  next_cfg.evt_sel = i_wdata[13:0];
        `MSS_A_IRQ_EN:   next_irq_en = i_wdata[6:0];
        `MSS_A_IRQ_CLR:  next_irq_stat = irq_stat & ~i_wdata[6:0];
        `MSS_A_REC_SEL: begin
          if (i_wdata[3:0] < 4'(`MSS_NREC)) begin
            next_rec_sel = i_wdata[3:0];
          end
        end
        default: next_rec_sel = rec_sel;
      endcase
    end
    next_irq_stat = next_irq_stat | rise;
    next_irq = |(next_irq_stat & next_irq_en);

    next_rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        `MSS_A_CTRL: begin
          next_rdata[`MSS_B_HEAT]  = cfg.heat_integral_mode;
          next_rdata[`MSS_B_SWEN]  = cfg.speed_switch_en;
          next_rdata[`MSS_B_SWPOL] = cfg.speed_switch_polarity;
          next_rdata[`MSS_B_STALL] = cfg.stall_too;
        end
        `MSS_A_START_T:  next_rdata = 32'(cfg.start_time);
        `MSS_A_SW_TO:    next_rdata = 32'(cfg.speed_switch_timeout);
        `MSS_A_HEAT_LIM: next_rdata = cfg.heat_limit;
        `MSS_A_EVT_SEL:  next_rdata = 32'(cfg.evt_sel);
        `MSS_A_IRQ_STAT: next_rdata = 32'(irq_stat);
        `MSS_A_IRQ_EN:   next_rdata = 32'(irq_en);
        `MSS_A_STATE:    next_rdata = 32'(flags);
        `MSS_A_REC_CNT:  next_rdata = 32'(rec_cnt);
        `MSS_A_REC_SEL:  next_rdata = 32'(rec_sel);
        `MSS_A_REC_TSL:  next_rdata = rd_rec.stamp[31:0];
        `MSS_A_REC_TSH:  next_rdata = 32'(rd_rec.stamp[47:32]);
        `MSS_A_REC_EVT:  next_rdata = 32'(rd_rec.event_code);
        `MSS_A_REC_DUR:  next_rdata = 32'(rd_rec.duration);
        `MSS_A_REC_PCT:  next_rdata = 32'(rd_rec.pct_used);
        `MSS_A_REC_THM:  next_rdata = 32'(rd_rec.thermal);
        `MSS_A_REC_L1:   next_rdata = 32'(rd_rec.l1);
        `MSS_A_REC_L2:   next_rdata = 32'(rd_rec.l2);
        `MSS_A_REC_L3:   next_rdata = 32'(rd_rec.l3);
        `MSS_A_REC_GRP:  next_rdata = 32'(rd_rec.group);
        default:         next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg.heat_integral_mode    <= 1'b0;
      cfg.speed_switch_en       <= 1'b0;
      cfg.speed_switch_polarity <= 1'b0;
      cfg.stall_too             <= 1'b0;
      cfg.start_time            <= `MSS_RST_START;
      cfg.speed_switch_timeout  <= `MSS_RST_SW_TO;
      cfg.heat_limit            <= `MSS_RST_HEAT;
      cfg.evt_sel               <= `MSS_RST_EVSEL;
      irq_en                    <= 7'h00;
      irq_stat                  <= 7'h00;
      rec_sel                   <= 4'h0;
      o_irq                     <= 1'b0;
      o_rdata                   <= 32'h00000000;
    end else if (i_ce) begin
      cfg      <= next_cfg;
      irq_en   <= next_irq_en;
      irq_stat <= next_irq_stat;
      rec_sel  <= next_rec_sel;
      o_irq    <= next_irq;
      o_rdata  <= next_rdata;
    end
  end

endmodule

// ===== core/motor_start_supervisor_map.svh
`ifndef MOTOR_START_SUPERVISOR_MAP_SVH
`define MOTOR_START_SUPERVISOR_MAP_SVH

// Register byte addresses
`define MSS_A_CTRL     8'h00
`define MSS_A_START_T  8'h04
`define MSS_A_SW_TO    8'h08
`define MSS_A_HEAT_LIM 8'h0c
`define MSS_A_EVT_SEL  8'h10
`define MSS_A_IRQ_STAT 8'h14
`define MSS_A_IRQ_EN   8'h18
`define MSS_A_IRQ_CLR  8'h1c
`define MSS_A_STATE    8'h20
`define MSS_A_REC_CNT  8'h24
`define MSS_A_REC_SEL  8'h28
`define MSS_A_REC_TSL  8'h2c
`define MSS_A_REC_TSH  8'h30
`define MSS_A_REC_EVT  8'h34
`define MSS_A_REC_DUR  8'h38
`define MSS_A_REC_PCT  8'h3c
`define MSS_A_REC_THM  8'h40
`define MSS_A_REC_L1   8'h44
`define MSS_A_REC_L2   8'h48
`define MSS_A_REC_L3   8'h4c
`define MSS_A_REC_GRP  8'h50

// Control register bit positions
`define MSS_B_HEAT  0
`define MSS_B_SWEN  1
`define MSS_B_SWPOL 2
`define MSS_B_STALL 3

// Reset values
`define MSS_RST_START  19'h00008
`define MSS_RST_SW_TO  19'h00008
`define MSS_RST_HEAT   32'h00010000
`define MSS_RST_EVSEL  14'h3fff

// Event indices
`define MSS_EV_MAX   0
`define MSS_EV_SET   1
`define MSS_EV_SW    2
`define MSS_EV_START 3
`define MSS_EV_STRIP 4
`define MSS_EV_CTRIP 5
`define MSS_EV_BLK   6
`define MSS_NEV      7

// Timing and record store
`define MSS_STEP_NS  5000000
`define MSS_CLK_NS   8
`define MSS_NREC     12
`define MSS_PCT_FULL 100

`endif

// ===== core/motor_start_supervisor_pkg.sv
package motor_start_supervisor_pkg;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_TIMING
  } sup_state_t;

  typedef struct packed {
    logic        heat_integral_mode;
    logic        speed_switch_en;
    logic        speed_switch_polarity;
    logic        stall_too;
    logic [18:0] start_time;
    logic [18:0] speed_switch_timeout;
    logic [31:0] heat_limit;
    logic [13:0] evt_sel;
  } cfg_t;

  typedef struct packed {
    logic [47:0] stamp;
    logic [2:0]  event_code;
    logic [18:0] duration;
    logic [15:0] pct_used;
    logic [15:0] thermal;
    logic [15:0] l1;
    logic [15:0] l2;
    logic [15:0] l3;
    logic [2:0]  group;
  } rec_t;

  typedef struct packed {
    logic [15:0] l1;
    logic [15:0] l2;
    logic [15:0] l3;
    logic [15:0] thermal;
    logic [15:0] i_sq;
    logic [2:0]  group;
  } meas_t;

endpackage

// ===== test/motor_start_supervisor_props.sv
`timescale 1ns/1ps
module motor_start_supervisor_props
  import motor_start_supervisor_pkg::*;
(
  // Clock, reset, enable
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  // Process inputs
  input wire logic        i_start_cond,
  input wire logic        i_stall_cond,
  input wire logic        i_block,
  input wire logic [47:0] i_stamp,
  // Function outputs
  input wire logic        o_start,
  input wire logic        o_trip,
  input wire logic        o_blocked,
  input wire logic [6:0]  o_evt_on,
  input wire logic [6:0]  o_evt_off,
  input wire logic [47:0] o_evt_stamp
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_run;
    i_start_cond && !i_block && i_ce;
  endsequence
  sequence s_held_block;
    i_start_cond && i_block && i_ce;
  endsequence
  sequence s_drop;
    !i_start_cond && !i_stall_cond && i_ce;
  endsequence
  a_start_follow: assert property (s_run |=> o_start)
    else $error("start output missing");
  a_block_out: assert property (s_held_block |=>
    o_blocked && !o_start && !o_trip)
    else $error("blocked output wrong");
  a_idle_quiet: assert property (s_drop |=>
    !o_start && !o_blocked && !o_trip)
    else $error("outputs active without condition");
  a_start_on: assert property (o_evt_on[3] |->
    o_start && !$past(o_start))
    else $error("start on event not at rise");
  a_start_off: assert property (o_evt_off[3] |->
    !o_start && $past(o_start))
    else $error("start off event not at fall");
  a_block_on: assert property (o_evt_on[6] |->
    o_blocked && !$past(o_blocked))
    else $error("blocked on event not at rise");
  a_pair_excl: assert property ((o_evt_on & o_evt_off) == 7'h00)
    else $error("on and off event together");
  a_evt_pulse: assert property (|o_evt_on |=>
    (o_evt_on & $past(o_evt_on)) == 7'h00)
    else $error("event pulse too long");
  a_evt_stamp: assert property (|(o_evt_on | o_evt_off) |->
    o_evt_stamp == $past(i_stamp))
    else $error("event stamp wrong");
  a_trip_start: assert property ($rose(o_trip) |-> $past(o_start))
    else $error("trip without prior start");
endmodule

bind motor_start_supervisor motor_start_supervisor_props u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_start_cond(i_start_cond), .i_stall_cond(i_stall_cond),
  .i_block(i_block), .i_stamp(i_stamp), .o_start(o_start),
  .o_trip(o_trip), .o_blocked(o_blocked), .o_evt_on(o_evt_on),
  .o_evt_off(o_evt_off), .o_evt_stamp(o_evt_stamp));

// ===== test/speed_switch_model.sv
`timescale 1ns/1ps
module speed_switch_model
  import motor_start_supervisor_pkg::*;
(
  // Clock and scenario controls
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic       i_nc,
  input  wire logic       i_answer,
  input  wire logic [7:0] i_delay,
  input  wire meas_t      i_level,
  // Towards the supervisor
  output logic            o_switch,
  output meas_t           o_meas
);
  logic [7:0] wait_cnt = 8'h00;
  // Measurement refreshes once a cycle
  always @(posedge i_clk) begin
    o_meas <= i_level;
    if (!i_run)
      wait_cnt <= 8'h00;
    else if (wait_cnt != 8'hff)
      wait_cnt <= wait_cnt + 8'h01;
  end
  // Contact closes when NO, opens when NC, once speed is reached
  assign o_switch = i_nc ^ (i_run && i_answer && wait_cnt > i_delay);
endmodule

// ===== test/motor_start_supervisor_bench.sv
`timescale 1ns/1ps
`include "motor_start_supervisor_map.svh"
module motor_start_supervisor_bench
  import motor_start_supervisor_pkg::*;
;
  localparam int TICK = 4;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1;
  logic [7:0]  i_addr = 8'h00, delay = 8'h01;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_block = 1'b0;
  logic        i_start_cond = 1'b0, i_stall_cond = 1'b0;
  logic        i_speed_switch, nc = 1'b0, answer = 1'b0;
  logic [47:0] i_stamp = 48'h0, o_evt_stamp;
  meas_t       i_meas, level = '0;
  logic        o_start, o_trip, o_blocked, o_irq;
  logic [6:0]  o_evt_on, o_evt_off, on_seen = '0, off_seen = '0;
  int          num_errors = 0, check_count = 0, n, t, k;
  logic [7:0]  ra [6] = '{`MSS_A_CTRL, `MSS_A_START_T, `MSS_A_SW_TO,
                          `MSS_A_EVT_SEL, `MSS_A_REC_CNT, 8'h7c};
  logic [31:0] rv [6] = '{0, 8, 8, 32'h3fff, 0, 0};

  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) i_stamp <= i_stamp + 48'h1;
  always @(negedge i_clk) begin
    on_seen  |= o_evt_on;
    off_seen |= o_evt_off;
  end

  motor_start_supervisor #(.TICK_CYCLES(TICK)) u_motor_start_supervisor (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_start_cond(i_start_cond), .i_stall_cond(i_stall_cond),
    .i_speed_switch(i_speed_switch), .i_block(i_block), .i_meas(i_meas),
    .i_stamp(i_stamp), .o_start(o_start), .o_trip(o_trip),
    .o_blocked(o_blocked), .o_irq(o_irq), .o_evt_on(o_evt_on),
    .o_evt_off(o_evt_off), .o_evt_stamp(o_evt_stamp));
  speed_switch_model u_speed_switch_model (
    .i_clk(i_clk), .i_run(i_start_cond), .i_nc(nc), .i_answer(answer),
    .i_delay(delay), .i_level(level), .o_switch(i_speed_switch),
    .o_meas(i_meas));

  function automatic logic [31:0] exp_count(input int c);
    return (c < `MSS_NREC) ? c + 1 : `MSS_NREC;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), e, o_rdata);
  endtask
  // Drive the start condition; a new start forgets earlier events
  task automatic run(input logic v);
    if (v) begin
      on_seen  = '0;
      off_seen = '0;
    end
    @(posedge i_clk) i_start_cond <= v;
  endtask
  task automatic wtrip(input int lim);
    n = 0;
    while (o_trip !== 1'b1 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(20000 * 8);
    num_errors++;
    results;
  end

  initial begin
    void'($urandom(93860));
    cyc(3);
    i_rst_n <= 1'b1;
    cyc(3);
    for (k = 0; k < 6; k++)
      rc(ra[k], rv[k]);
    wr(`MSS_A_REC_SEL, 0);
    for (k = 0; k <= 12; k++) begin
      t = $urandom_range(4, 1);
      level <= {16'(k), 67'({$urandom, $urandom, $urandom})};
      wr(`MSS_A_START_T, t);
      run(1'b1);
      wtrip(200);
      chk("trip time", 1, n >= t * TICK && n <= t * TICK + 4);
      run(1'b0);
      cyc(3);
      chk("set trip on", 7'h1a, on_seen & 7'h1a);
      chk("set trip off", 7'h1a, off_seen & 7'h1a);
      rc(`MSS_A_REC_CNT, exp_count(k));
      rc(`MSS_A_REC_L1, k);
      rc(`MSS_A_REC_GRP, level.group);
      rc(`MSS_A_REC_DUR, t);
      rc(`MSS_A_REC_PCT, `MSS_PCT_FULL);
      rc(`MSS_A_REC_EVT, `MSS_EV_STRIP);
    end
    wr(`MSS_A_REC_SEL, 11);
    rc(`MSS_A_REC_L1, 1);
    wr(`MSS_A_REC_SEL, 12);
    rc(`MSS_A_REC_SEL, 11);
    wr(`MSS_A_START_T, 100);
    wr(`MSS_A_SW_TO, 2);
    for (k = 0; k < 5; k++) begin
      nc     <= k[0];
      answer <= k[1];
      wr(`MSS_A_CTRL, {k[0], (k < 4), 1'b0});
      run(1'b1);
      cyc(2 * TICK + 8);
      chk("switch trip", k < 4 && !k[1], o_trip);
      chk("switch event", k < 4 && !k[1], on_seen[2]);
      run(1'b0);
      cyc(3);
    end
    t = $urandom_range(255, 1);
    level.i_sq <= 16'(t);
    wr(`MSS_A_HEAT_LIM, 3 * t);
    wr(`MSS_A_CTRL, 1);
    run(1'b1);
    wtrip(100);
    chk("heat time", 1, n >= 3 * TICK && n <= 3 * TICK + 5);
    cyc(1);
    chk("heat event", 7'h21, on_seen & 7'h21);
    run(1'b0);
    level.i_sq <= 16'h0;
    run(1'b1);
    cyc(40);
    chk("cold trip", 0, o_trip);
    i_ce    <= 1'b0;
    i_block <= 1'b1;
    cyc(3);
    chk("frozen", 1, {o_blocked, o_start});
    i_ce    <= 1'b1;
    i_block <= 1'b0;
    cyc(1);
    run(1'b0);
    for (k = 0; k < 2; k++) begin
      i_stall_cond <= 1'b1;
      wr(`MSS_A_CTRL, k << `MSS_B_STALL);
      cyc(3);
      chk("stall start", k, o_start);
      i_stall_cond <= 1'b0;
      wr(`MSS_A_EVT_SEL, 32'h8 << (7 * k));
      run(1'b1);
      cyc(3);
      run(1'b0);
      cyc(3);
      chk("sel on", k ? 0 : 8, on_seen);
      chk("sel off", k ? 8 : 0, off_seen);
    end
    wr(`MSS_A_IRQ_CLR, 32'h7f);
    wr(`MSS_A_IRQ_EN, 32'h40);
    i_block <= 1'b1;
    run(1'b1);
    cyc(3);
    chk("blocked", 1, o_blocked);
    chk("blocked irq", 1, o_irq);
    run(1'b0);
    cyc(2);
    chk("irq sticky", 1, o_irq);
    wr(`MSS_A_IRQ_EN, 0);
    cyc(2);
    chk("irq masked", 0, o_irq);
    wr(`MSS_A_IRQ_EN, 32'h40);
    wr(`MSS_A_IRQ_CLR, 32'h7f);
    cyc(2);
    chk("irq cleared", 0, o_irq);
    rc(`MSS_A_IRQ_STAT, 0);
    results;
  end
endmodule
